// ### core/strap_cfg_pkg.sv
/*
  Package for the strap-in configuration and access-mode selector: register offsets,
  field positions, reset values, strap encodings and the state enumeration.
  Assumes a 20 MHz core clock and a 32-bit APB register bus.
*/
package strap_cfg_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] REG_STRAP_STATUS = 8'h00;   // latched straps, read only
  localparam logic [7:0] REG_LED_MODE     = 8'h04;   // led indication mode
  localparam logic [7:0] REG_PORT1_CTRL   = 8'h08;   // effective port 1 settings
  localparam logic [7:0] REG_EEPROM_CTRL  = 8'h0C;   // eeprom presence / status

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int LED_MODE_LSB   = 4;                 // two-bit field [5:4]
  localparam int ST_SPEED_BIT   = 0;
  localparam int ST_AUTONEG_BIT = 1;
  localparam int ST_MODE_LSB    = 2;                 // access mode [3:2]
  localparam int ST_VALID_BIT   = 4;
  localparam int P1_AUTONEG_BIT = 0;
  localparam int P1_SPEED_BIT   = 1;                 // 1 = 100 Mbit/s
  localparam int EE_PRESENT_BIT = 0;
  localparam int EE_DONE_BIT    = 1;
  localparam int EE_DEFAULT_BIT = 2;

  // ****************************************************************
  // reset values and encodings
  // ****************************************************************
  localparam logic [1:0] LED_MODE_RESET    = 2'h0;   // speed / link-activity
  localparam logic [1:0] MODE_EEPROM_HOST  = 2'h0;
  localparam logic [1:0] MODE_SPI_CLIENT   = 2'h2;
  localparam logic [1:0] MODE_MGMT         = 2'h3;

  // ****************************************************************
  // timing: eeprom answer window after reset
  // ****************************************************************
  localparam int CLK_MHZ          = 20;
  localparam int EE_WAIT_US       = 100;
  localparam int EE_WAIT_CYCLES   = EE_WAIT_US * CLK_MHZ;
  localparam logic [11:0] EE_WAIT_LAST = 12'(EE_WAIT_CYCLES - 1);

  typedef enum logic [2:0] {
    ST_LATCH = 3'b001,
    ST_PROBE = 3'b010,
    ST_RUN   = 3'b100
  } cfg_state_t;

endpackage

// ### core/client_select_edge.sv
/*
  Serial client select front end: detects the start of a transaction and gates the
  serial data output enable. Assumes the select input is synchronous to core_clk.
*/
module client_select_edge (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clientMode,
  input  wire logic serial_client_select_n,
  output logic      txnStart,
  output logic      selected
);

  typedef struct packed {
    logic selPrev_r;
  } edge_state_t;

  edge_state_t st_r;
  edge_state_t st_nxt;

  // remember the last select level; reset high so no false start
  always_comb begin
    st_nxt.selPrev_r = serial_client_select_n;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.selPrev_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign txnStart = clientMode & st_r.selPrev_r & ~serial_client_select_n;
  assign selected = clientMode & ~serial_client_select_n;

endmodule

// ### core/strap_config_access_select.sv
/*
  Strap-in configuration loader and register access selector for a three-port switch.
  Latches the strap levels on the multiplexed led pins once after reset, derives port 1
  speed and auto-negotiation, selects the register access mode, and exposes all of it
  over an APB slave. Assumes all pin inputs are synchronous to core_clk.
*/
// The implementer's own choices: the APB slave port and the register offsets.
// Function
// - while select is high, ignore the client bus and float the data output.
// - a falling edge of select starts a new client transaction.
// - autoneg off forces port 1 to 100 if speed strap high, else 10.
// - autoneg strap high enables port 1 autoneg; low disables it.
// - leds default to speed and link/activity; two-bit field selects mode.
// - port 2 led pins form access-mode strap; 00 means eeprom host mode.
// - with no eeprom answering, use register defaults plus strap values.
// - in client mode register read data goes out on the data output pin.
// - host mode drives serial clock out; management mode takes it in.
module strap_config_access_select (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        port1_led_first_in,
  input  wire logic        port1_led_second_in,
  input  wire logic        port2_led_first_in,
  input  wire logic        port2_led_second_in,
  input  wire logic [1:0]  ledIndication,
  output logic             port1_led_first,
  output logic             port1_led_second,
  output logic             port2_led_first,
  output logic             port2_led_second,
  output logic             ledOe_n,
  input  wire logic        port1Speed100,
  input  wire logic        port1Link,
  input  wire logic        port2Speed100,
  input  wire logic        port2Link,
  input  wire logic        eepromAck,
  input  wire logic        eepromDone,
  input  wire logic        serial_client_select_n,
  input  wire logic        clientReadBit,
  output logic             clientTxnStart,
  output logic             serial_client_data_out,
  output logic             serialDataOe_n,
  input  wire logic        hostSerialClk,
  input  wire logic        serialClkIn,
  output logic             serialClkOut,
  output logic             serialClkOe_n,
  output logic             serialClkToCore,
  output logic             port1AutonegEn,
  output logic             port1Force100,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    strap_cfg_pkg::cfg_state_t fsm_r;
    logic                      speedStrap_r;
    logic                      autonegStrap_r;
    logic [1:0]                modeStrap_r;
    logic                      strapValid_r;
    logic [1:0]                ledMode_r;
    logic                      eePresent_r;
    logic                      eeDone_r;
    logic                      eeDefault_r;
    logic [11:0]               eeCnt_r;
    logic [31:0]               prdata_r;
    logic                      pslverr_r;
    logic                      dataOut_r;
  } cfg_regs_t;

  cfg_regs_t st_r;
  cfg_regs_t st_nxt;
  logic      txnStart;
  logic      selected;
  logic      clientMode;
  logic      hostMode;
  logic      apbAccess;
  logic      strapLatched;

  assign clientMode   = st_r.strapValid_r && (st_r.modeStrap_r == strap_cfg_pkg::MODE_SPI_CLIENT);
  assign hostMode     = st_r.strapValid_r && (st_r.modeStrap_r == strap_cfg_pkg::MODE_EEPROM_HOST);
  assign apbAccess    = psel & penable;
  assign strapLatched = st_r.strapValid_r;

  client_select_edge u_sel (
    .core_clk               (core_clk),
    .rst_n                  (rst_n),
    .clientMode             (clientMode),
    .serial_client_select_n (serial_client_select_n),
    .txnStart               (txnStart),
    .selected               (selected)
  );

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  // straps are sampled in the first cycle after release, never again
  always_comb begin
    st_nxt           = st_r;
    st_nxt.pslverr_r = 1'b0;
    case (st_r.fsm_r)
      strap_cfg_pkg::ST_LATCH: begin
        st_nxt.speedStrap_r   = port1_led_first_in;
        st_nxt.autonegStrap_r = port1_led_second_in;
        st_nxt.modeStrap_r    = {port2_led_first_in, port2_led_second_in};
        st_nxt.strapValid_r   = 1'b1;
        st_nxt.fsm_r          = strap_cfg_pkg::ST_PROBE;
      end
      strap_cfg_pkg::ST_PROBE: begin
        // only host mode waits for an eeprom; other modes run at once
        if (st_r.modeStrap_r != strap_cfg_pkg::MODE_EEPROM_HOST) begin
          st_nxt.fsm_r = strap_cfg_pkg::ST_RUN;
        end else if (eepromAck) begin
          st_nxt.eePresent_r = 1'b1;
          st_nxt.eeDone_r    = eepromDone;
          if (eepromDone) begin
            st_nxt.fsm_r = strap_cfg_pkg::ST_RUN;
          end
        end else if (!st_r.eePresent_r && st_r.eeCnt_r == strap_cfg_pkg::EE_WAIT_LAST) begin
          st_nxt.eeDefault_r = 1'b1;
          st_nxt.fsm_r       = strap_cfg_pkg::ST_RUN;
        end else begin
          st_nxt.eeCnt_r = st_r.eeCnt_r + 12'h001;
        end
      end
      strap_cfg_pkg::ST_RUN: begin
        st_nxt.fsm_r = strap_cfg_pkg::ST_RUN;
      end
      default: begin
        st_nxt.fsm_r = strap_cfg_pkg::ST_LATCH;
      end
    endcase

    // apb: writes and read errors take effect in the access phase; read data is captured in the setup phase
    if (apbAccess && pwrite) begin
      if (paddr == strap_cfg_pkg::REG_LED_MODE) begin
        st_nxt.ledMode_r = pwdata[strap_cfg_pkg::LED_MODE_LSB +: 2];
      end else if (paddr != strap_cfg_pkg::REG_EEPROM_CTRL) begin
        st_nxt.pslverr_r = (paddr != strap_cfg_pkg::REG_STRAP_STATUS) &&
                           (paddr != strap_cfg_pkg::REG_PORT1_CTRL);
      end
    end
    if (psel && !penable && !pwrite) begin
      st_nxt.prdata_r = 32'h0000_0000;
      case (paddr)
        strap_cfg_pkg::REG_STRAP_STATUS: begin
          st_nxt.prdata_r[strap_cfg_pkg::ST_SPEED_BIT]        = st_r.speedStrap_r;
          st_nxt.prdata_r[strap_cfg_pkg::ST_AUTONEG_BIT]      = st_r.autonegStrap_r;
          st_nxt.prdata_r[strap_cfg_pkg::ST_MODE_LSB +: 2]    = st_r.modeStrap_r;
          st_nxt.prdata_r[strap_cfg_pkg::ST_VALID_BIT]        = st_r.strapValid_r;
        end
        strap_cfg_pkg::REG_LED_MODE: begin
          st_nxt.prdata_r[strap_cfg_pkg::LED_MODE_LSB +: 2]   = st_r.ledMode_r;
        end
        strap_cfg_pkg::REG_PORT1_CTRL: begin
          st_nxt.prdata_r[strap_cfg_pkg::P1_AUTONEG_BIT]      = st_r.autonegStrap_r;
          st_nxt.prdata_r[strap_cfg_pkg::P1_SPEED_BIT]        = st_r.speedStrap_r;
        end
        strap_cfg_pkg::REG_EEPROM_CTRL: begin
          st_nxt.prdata_r[strap_cfg_pkg::EE_PRESENT_BIT]      = st_r.eePresent_r;
          st_nxt.prdata_r[strap_cfg_pkg::EE_DONE_BIT]         = st_r.eeDone_r;
          st_nxt.prdata_r[strap_cfg_pkg::EE_DEFAULT_BIT]      = st_r.eeDefault_r;
        end
        default: begin
          st_nxt.prdata_r = 32'h0000_0000;
        end
      endcase
    end
    if (apbAccess && !pwrite) begin
      st_nxt.pslverr_r = (paddr != strap_cfg_pkg::REG_STRAP_STATUS) &&
                         (paddr != strap_cfg_pkg::REG_LED_MODE) &&
                         (paddr != strap_cfg_pkg::REG_PORT1_CTRL) &&
                         (paddr != strap_cfg_pkg::REG_EEPROM_CTRL);
    end

    // client read data is registered so the pin never glitches mid bit
    st_nxt.dataOut_r = selected ? clientReadBit : 1'b0;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.fsm_r          <= strap_cfg_pkg::ST_LATCH;
      st_r.speedStrap_r   <= 1'b0;
      st_r.autonegStrap_r <= 1'b0;
      st_r.modeStrap_r    <= strap_cfg_pkg::MODE_EEPROM_HOST;
      st_r.strapValid_r   <= 1'b0;
      st_r.ledMode_r      <= strap_cfg_pkg::LED_MODE_RESET;
      st_r.eePresent_r    <= 1'b0;
      st_r.eeDone_r       <= 1'b0;
      st_r.eeDefault_r    <= 1'b0;
      st_r.eeCnt_r        <= 12'h000;
      st_r.prdata_r       <= 32'h0000_0000;
      st_r.pslverr_r      <= 1'b0;
      st_r.dataOut_r      <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // pins are inputs until straps are caught, then become led drivers
  assign ledOe_n          = ~strapLatched;
  assign port1_led_first  = (st_r.ledMode_r == strap_cfg_pkg::LED_MODE_RESET) ? port1Speed100 : ledIndication[0];
  assign port1_led_second = (st_r.ledMode_r == strap_cfg_pkg::LED_MODE_RESET) ? port1Link : ledIndication[1];
  assign port2_led_first  = (st_r.ledMode_r == strap_cfg_pkg::LED_MODE_RESET) ? port2Speed100 : ledIndication[0];
  assign port2_led_second = (st_r.ledMode_r == strap_cfg_pkg::LED_MODE_RESET) ? port2Link : ledIndication[1];

  assign port1AutonegEn = st_r.autonegStrap_r;
  assign port1Force100  = ~st_r.autonegStrap_r & st_r.speedStrap_r;

  assign clientTxnStart         = txnStart;
  assign serial_client_data_out = st_r.dataOut_r;
  assign serialDataOe_n         = ~selected;

  // host mode makes the serial clock; other modes listen to the pin
  assign serialClkOut    = hostMode & hostSerialClk;
  assign serialClkOe_n   = ~hostMode;
  assign serialClkToCore = hostMode ? hostSerialClk : serialClkIn;

  assign prdata  = st_r.prdata_r;
  assign pready  = 1'b1;
  assign pslverr = apbAccess & st_nxt.pslverr_r;

endmodule

// ### verification/strap_cfg_checker.sv
/*
  Checker for the strap loader: select gating, clock routing and strap hold.
  Assumes it is bound to strap_config_access_select and sees only its ports.
*/
module strap_cfg_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic serial_client_select_n,
  input wire logic serialDataOe_n,
  input wire logic clientTxnStart,
  input wire logic clientReadBit,
  input wire logic serial_client_data_out,
  input wire logic port1Force100,
  input wire logic port1AutonegEn,
  input wire logic serialClkOe_n,
  input wire logic serialClkOut,
  input wire logic hostSerialClk,
  input wire logic serialClkToCore,
  input wire logic serialClkIn,
  input wire logic ledOe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // properties
  // ****************************************************************
  // one domain, so clock and reset are given once for all
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  float_deselect_a: assert property (serial_client_select_n |-> serialDataOe_n)
    else $error("data output enabled while deselected");
  start_needs_fall_a: assert property (clientTxnStart |-> $fell(serial_client_select_n))
    else $error("transaction start without a select fall");
  fall_gives_start_a: assert property ($fell(serial_client_select_n) && !serialDataOe_n |-> clientTxnStart)
    else $error("select fall in client mode missed");
  force_only_off_a: assert property (port1Force100 |-> !port1AutonegEn)
    else $error("speed forced while autoneg enabled");
  read_bit_out_a: assert property (!serialDataOe_n && $past(!serialDataOe_n)
      |-> serial_client_data_out == $past(clientReadBit))
    else $error("client data output not the read bit");
  host_clk_drive_a: assert property (!serialClkOe_n |-> serialClkOut == hostSerialClk)
    else $error("host mode clock not driven out");
  clk_input_used_a: assert property (serialClkOe_n |-> serialClkToCore == serialClkIn)
    else $error("pin clock not routed to core");
  straps_held_a: assert property (!ledOe_n && !$past(ledOe_n)
      |-> $stable(port1AutonegEn) && $stable(port1Force100))
    else $error("latched strap changed while leds driven");
  // main scenarios reached
  cov_start_c: cover property (clientTxnStart);
  cov_force_c: cover property (port1Force100);
  cov_host_c: cover property (!serialClkOe_n && !ledOe_n);
endmodule

bind strap_config_access_select strap_cfg_checker i_chk (
  .core_clk, .rst_n, .serial_client_select_n, .serialDataOe_n, .clientTxnStart, .clientReadBit,
  .serial_client_data_out, .port1Force100, .port1AutonegEn, .serialClkOe_n, .serialClkOut,
  .hostSerialClk, .serialClkToCore, .serialClkIn, .ledOe_n
);

// ### verification/host_side_model.sv
/*
  Far side model: an eeprom that answers 20 cycles after reset when present,
  and a host that runs one 8-cycle select frame per rising go. Core clock only.
*/
module host_side_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic eePresent,
  input wire logic go,
  output logic     eepromAck,
  output logic     eepromDone,
  output logic     serial_client_select_n,
  output logic     clientReadBit,
  output logic     hostSerialClk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] eeCnt_r;
  logic [3:0] bitCnt_r;
  logic       goQ_r;
  // ****************************************************************
  // behaviour
  // ****************************************************************
  // done always arrives with the answer
  assign eepromDone = eepromAck;
  // read bit flips every cycle so a stale sample cannot pass for a fresh one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {eepromAck, hostSerialClk, clientReadBit, goQ_r} <= 4'h0;
      serial_client_select_n <= 1'b1;
      eeCnt_r <= 5'h00;
      bitCnt_r <= 4'h0;
    end else begin
      hostSerialClk <= ~hostSerialClk;
      clientReadBit <= ~clientReadBit;
      goQ_r <= go;
      if (eePresent && eeCnt_r != 5'h14) eeCnt_r <= eeCnt_r + 5'h01;
      eepromAck <= eePresent && eeCnt_r == 5'h13;
      if (go && !goQ_r) begin
        serial_client_select_n <= 1'b0;
        bitCnt_r <= 4'h8;
      end else if (bitCnt_r != 4'h0) begin
        bitCnt_r <= bitCnt_r - 4'h1;
        if (bitCnt_r == 4'h1) serial_client_select_n <= 1'b1;
      end
    end
  end
endmodule

// ### verification/testbench.sv
/*
  Testbench: four strap sets, each checked over apb, at the pins and with a client frame.
  Assumes the design, the far side model and the checker bind are compiled with it.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        port1_led_first_in = 1'b0, port1_led_second_in = 1'b0, port2_led_first_in = 1'b0;
  logic        port2_led_second_in = 1'b0, port1Speed100 = 1'b0, port1Link = 1'b0, eePresent = 1'b0;
  logic        go = 1'b0, port2Speed100 = 1'b0, port2Link = 1'b0, serialClkIn, err;
  logic        port1_led_first, port1_led_second, ledOe_n, eepromAck, eepromDone, pready, pslverr;
  logic        serial_client_select_n, clientReadBit, clientTxnStart, serial_client_data_out;
  logic        serialDataOe_n, hostSerialClk, serialClkOut, serialClkOe_n, serialClkToCore;
  logic        port1AutonegEn, port1Force100, port2_led_first, port2_led_second;
  logic [1:0]  ledIndication = 2'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, cyc = 32'h0, txnCnt = 32'h0, oeCnt = 32'h0, t0, o0;
  logic [4:0]  tbl [4] = '{5'h01, 5'h12, 5'h08, 5'h0F}; // {eeprom, mode, autoneg, speed}
  int          errorCnt = 0, nChecks = 0;

  // every pin by name, so a port renamed or removed in the design cannot stay silently misconnected
  strap_config_access_select i_dut (
    .core_clk               (core_clk),               .rst_n                  (rst_n),
    .port1_led_first_in     (port1_led_first_in),     .port1_led_second_in    (port1_led_second_in),
    .port2_led_first_in     (port2_led_first_in),     .port2_led_second_in    (port2_led_second_in),
    .ledIndication          (ledIndication),          .port1_led_first        (port1_led_first),
    .port1_led_second       (port1_led_second),       .port2_led_first        (port2_led_first),
    .port2_led_second       (port2_led_second),       .ledOe_n                (ledOe_n),
    .port1Speed100          (port1Speed100),          .port1Link              (port1Link),
    .port2Speed100          (port2Speed100),          .port2Link              (port2Link),
    .eepromAck              (eepromAck),              .eepromDone             (eepromDone),
    .serial_client_select_n (serial_client_select_n), .clientReadBit          (clientReadBit),
    .clientTxnStart         (clientTxnStart),         .serial_client_data_out (serial_client_data_out),
    .serialDataOe_n         (serialDataOe_n),         .hostSerialClk          (hostSerialClk),
    .serialClkIn            (serialClkIn),            .serialClkOut           (serialClkOut),
    .serialClkOe_n          (serialClkOe_n),          .serialClkToCore        (serialClkToCore),
    .port1AutonegEn         (port1AutonegEn),         .port1Force100          (port1Force100),
    .psel                   (psel),                   .penable                (penable),
    .pwrite                 (pwrite),                 .paddr                  (paddr),
    .pwdata                 (pwdata),                 .prdata                 (prdata),
    .pready                 (pready),                 .pslverr                (pslverr)
  );
  host_side_model i_host (.core_clk, .rst_n, .eePresent, .go, .eepromAck, .eepromDone,
                          .serial_client_select_n, .clientReadBit, .hostSerialClk);

  // 50 ns period; pin clock input runs at a quarter of the core clock rate
  always #25 core_clk = ~core_clk;
  assign serialClkIn = cyc[1];

  // cycle count, client event counts and the hang limit
  always @(posedge core_clk) begin
    cyc <= cyc + 32'h1;
    if (clientTxnStart === 1'b1) txnCnt <= txnCnt + 32'h1;
    if (serialDataOe_n === 1'b0) oeCnt <= oeCnt + 32'h1;
    if (cyc == 32'h4E20) begin
      errorCnt++;
      finishTest();
    end
  end

  task automatic finishTest();
    $display("checks %0d, mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  // one apb transfer; no wait count assumed, it waits for pready and the hang limit ends a stall
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // each strap set: reset, eeprom window, inverted pins, registers, pins, one frame
  initial begin
    for (int i = 0; i < 4; i++) begin
      {eePresent, port2_led_first_in, port2_led_second_in, port1_led_second_in, port1_led_first_in} <= tbl[i];
      rst_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (2100) @(posedge core_clk);
      {port2_led_first_in, port2_led_second_in, port1_led_second_in, port1_led_first_in} <= ~tbl[i][3:0];
      apb(1'b0, 8'h00, 32'h0);
      check32(rd, {27'h0, 1'b1, tbl[i][3:0]});
      check1(port1AutonegEn, tbl[i][1]);
      check1(port1Force100, tbl[i][0] & ~tbl[i][1]);
      check1(serialClkOe_n, tbl[i][3:2] != 2'h0);
      check1(ledOe_n, 1'b0);
      if (tbl[i][3:2] == 2'h0) begin
        apb(1'b0, 8'h0C, 32'h0);
        check32(rd & 32'h5, tbl[i][4] ? 32'h1 : 32'h4);
      end
      t0 = txnCnt;
      o0 = oeCnt;
      go <= 1'b1;
      repeat (12) @(posedge core_clk);
      go <= 1'b0;
      check32(txnCnt - t0, tbl[i][3:2] == 2'h2 ? 32'h1 : 32'h0);
      check32(oeCnt - o0, tbl[i][3:2] == 2'h2 ? 32'h8 : 32'h0);
      if (i == 0) begin
        port1Speed100 <= 1'b1;
        port2Speed100 <= 1'b1;
        ledIndication <= 2'h2;
        apb(1'b0, 8'h04, 32'h0);
        check32(rd, 32'h0);
        check1(port1_led_first, 1'b1);
        check1(port1_led_second, 1'b0);
        check1(port2_led_first, 1'b1);
        check1(port2_led_second, 1'b0);
        apb(1'b1, 8'h04, 32'h30);
        apb(1'b0, 8'h04, 32'h0);
        check32(rd, 32'h30);
        check1(port1_led_first, 1'b0);
        check1(port1_led_second, 1'b1);
        check1(port2_led_first, 1'b0);
        check1(port2_led_second, 1'b1);
        apb(1'b1, 8'h00, 32'h1F);
        check1(err, 1'b0);
        apb(1'b0, 8'h10, 32'h0);
        check1(err, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        check32(rd, 32'h11);
      end
    end
    finishTest();
  end
endmodule
